// ---- design/sdram_cmd_core.v ----
// Local design decisions: the Wishbone register port and the register addresses.
`timescale 1ns/1ps
`include "sdram_cmd_map.vh"
// How it works
// RULE1: Host holds gate and masks high 100us
// RULE2: Precharge, two refreshes, then mode load
// RULE3: Mode load may precede the refreshes
// RULE4: Mode load captures all twelve address bits
// RULE5: Mode fields: options, latency, type, length
// RULE6: Host loads mode only with banks idle
// RULE7: Host waits two cycles after mode load
// RULE8: First read word after programmed latency (codes below two act as two)
// RULE9: Start column given, rest generated inside
// RULE10: Burst of 1, 2, 4, 8 or page
// RULE11: Burst order sequential or interleaved
// RULE12: Gate rising resumes without extra edge
// RULE13: Host idles banks before low power
// RULE14: Chip select and strobes decode commands
// RULE15: Bank bit and auto-close bit selection
// RULE16: Column uses low eight address bits
// RULE17: Each bank tracks its own state
// RULE18: Refresh and mode load need idle banks
// RULE19: Burst write starts with the command
// RULE20: Single write stores one word only
// RULE21: All inputs sampled on rising edge
module sdram_cmd_core #(
    parameter COL_W = 8,
    parameter PWR_CYC = `PWR_WAIT_US * `CLK_MHZ
) (
    input wire clk_i,
    input wire rst_i,
    input wire [7:0] wb_adr_i,
    input wire [31:0] wb_dat_i,
    input wire [3:0] wb_sel_i,
    input wire wb_we_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    input wire cke_i,
    input wire cs_n_i,
    input wire ras_n_i,
    input wire cas_n_i,
    input wire we_n_i,
    input wire [11:0] addr_i,
    input wire [1:0] dqm_i,
    input wire [15:0] dq_i,
    output reg [15:0] dq_o,
    output reg dq_oe_o
);
    localparam DEPTH = 2 << COL_W;
    localparam PIPE = 5;

    // ==========================================
    // State
    reg [11:0] mode_ff;
    reg wprot_ff;
    reg [2:0] err_ff;
    reg [15:0] pwr_cnt_ff;
    reg pwr_ok_ff;
    reg pre_seen_ff;
    reg [2:0] ref_cnt_ff;
    reg mode_seen_ff;
    reg [1:0] mrs_gap_ff;
    reg bact_ff;
    reg bbank_ff;
    reg bwr_ff;
    reg [COL_W-1:0] bstart_ff;
    reg [COL_W-1:0] bidx_ff;
    reg [15:0] mem_ff [0:DEPTH-1];
    reg [15:0] pipe_d_ff [0:PIPE-1];
    reg [PIPE-1:0] pipe_v_ff;
    integer i;

    wire [5:0] st0;
    wire [5:0] st1;
    wire idle0;
    wire idle1;
    wire [COL_W-1:0] col;
    wire [2:0] cmd;
    wire live;
    wire bank;
    wire ap;
    wire [COL_W-1:0] cmd_col;
    wire both_idle;
    wire bank_open;
    wire [2:0] bl;
    wire [2:0] cl;
    wire single_wr;
    wire [COL_W-1:0] last_idx;
    wire last_step;
    wire step;
    wire [COL_W:0] mem_idx;
    wire [COL_W:0] cmd_idx;
    wire wb_req;
    wire [11:0] status_lo;

    // ==========================================
    // Command decode
    // RULE12: gate used on the very edge it rises
    assign live = cke_i;
    // RULE14: deselect ignored, strobes give command
    // RULE21: taken at the rising edge
    assign cmd = cs_n_i ? `CMD_NOP : {ras_n_i, cas_n_i, we_n_i};
    // RULE15: bank and auto-close bits
    assign bank = addr_i[`BANK_BIT];
    assign ap = addr_i[`AP_BIT];
    // RULE16: bits 8 and 9 dropped for columns
    assign cmd_col = addr_i[COL_W-1:0];
    assign both_idle = idle0 && idle1;
    assign bank_open = bank ? !idle1 : !idle0;
    // RULE5: mode register fields
    assign bl = mode_ff[`MR_BL_MSB:`MR_BL_LSB];
    assign cl = mode_ff[`MR_CL_MSB:`MR_CL_LSB];
    // RULE20: single write mode
    assign single_wr = (mode_ff[`MR_WM_MSB:`MR_WM_LSB] == `WM_SINGLE);

    wire is_rd = live && cmd == `CMD_READ && bank_open;
    wire is_wr = live && cmd == `CMD_WRITE && bank_open;
    wire is_act = live && cmd == `CMD_ACT;
    wire is_pre = live && cmd == `CMD_PRE;
    wire is_bst = live && cmd == `CMD_BST;
    // RULE18: only with both banks idle
    wire is_ref = live && cmd == `CMD_REF && both_idle;
    wire is_mrs = live && cmd == `CMD_MRS && both_idle;
    wire is_cmd = live && cmd != `CMD_NOP;
    wire bad = live && ((cmd == `CMD_READ || cmd == `CMD_WRITE) && !bank_open
        || (cmd == `CMD_REF || cmd == `CMD_MRS) && !both_idle);

    // RULE10: length from burst length field
    assign last_idx = (bl == `BL_2) ? {{(COL_W-1){1'b0}}, 1'b1} :
        (bl == `BL_4) ? {{(COL_W-2){1'b0}}, 2'h3} :
        (bl == `BL_8) ? {{(COL_W-3){1'b0}}, 3'h7} : {COL_W{1'b0}};
    wire page = (bl == `BL_PAGE);
    wire wr_len1 = single_wr || (!page && last_idx == {COL_W{1'b0}});

    assign step = bact_ff && live;
    assign last_step = step && !page && (bidx_ff == last_idx);
    wire pre_hit = is_pre && (ap || bank == bbank_ff);
    wire kill = is_rd || is_wr || is_bst || pre_hit;
    wire end_old = bact_ff && live && (last_step ||
        ((is_rd || is_wr) && bank != bbank_ff));

    // RULE9: column generation from the start column
    burst_col #(
        .COL_W(COL_W)
    ) u_col (
        .start_i(bstart_ff),
        .idx_i(bidx_ff),
        .bl_i(bl),
        .bt_i(mode_ff[`MR_BT_BIT]),
        .col_o(col)
    );

    assign mem_idx = {bbank_ff, col};
    assign cmd_idx = {bank, cmd_col};

    // ==========================================
    // Bank states
    bank_state u_bank0 (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .act_i(is_act && !bank),
        .rd_i(is_rd && !bank),
        .wr_i(is_wr && !bank),
        .ap_i(ap),
        .pre_i(is_pre && (ap || !bank)),
        .stop_i(is_bst),
        .done_i(end_old && !bbank_ff || is_wr && !bank && wr_len1),
        .state_o(st0),
        .idle_o(idle0)
    );

    bank_state u_bank1 (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .act_i(is_act && bank),
        .rd_i(is_rd && bank),
        .wr_i(is_wr && bank),
        .ap_i(ap),
        .pre_i(is_pre && (ap || bank)),
        .stop_i(is_bst),
        .done_i(end_old && bbank_ff || is_wr && bank && wr_len1),
        .state_o(st1),
        .idle_o(idle1)
    );

    // ==========================================
    // Burst engine
    always @(posedge clk_i) begin
        if (rst_i) begin
            bact_ff <= 1'b0;
            bbank_ff <= 1'b0;
            bwr_ff <= 1'b0;
            bstart_ff <= {COL_W{1'b0}};
            bidx_ff <= {COL_W{1'b0}};
        end else if (is_rd) begin
            // RULE8: read engine starts at step zero
            bact_ff <= 1'b1;
            bbank_ff <= bank;
            bwr_ff <= 1'b0;
            bstart_ff <= cmd_col;
            bidx_ff <= {COL_W{1'b0}};
        end else if (is_wr) begin
            // RULE19: word zero written with the command
            bact_ff <= !wr_len1;
            bbank_ff <= bank;
            bwr_ff <= 1'b1;
            bstart_ff <= cmd_col;
            bidx_ff <= {{(COL_W-1){1'b0}}, 1'b1};
        end else if (kill || last_step) begin
            // RULE17: stop or close ends the burst
            bact_ff <= 1'b0;
        end else if (step) begin
            bidx_ff <= bidx_ff + {{(COL_W-1){1'b0}}, 1'b1};
        end
    end

    // ==========================================
    // Storage, byte masked
    always @(posedge clk_i) begin
        if (is_wr && !wprot_ff) begin
            if (!dqm_i[0]) mem_ff[cmd_idx][7:0] <= dq_i[7:0];
            if (!dqm_i[1]) mem_ff[cmd_idx][15:8] <= dq_i[15:8];
        end else if (step && bwr_ff && !kill && !wprot_ff) begin
            if (!dqm_i[0]) mem_ff[mem_idx][7:0] <= dq_i[7:0];
            if (!dqm_i[1]) mem_ff[mem_idx][15:8] <= dq_i[15:8];
        end
    end

    // ==========================================
    // Read latency line
    // Latencies below two act as two; data cannot leave before one flop
    wire [2:0] cl_eff = (cl < 3'h2) ? 3'h2 : cl;
    wire rd_now = step && !bwr_ff && !kill;

    always @(posedge clk_i) begin
        if (rst_i) begin
            pipe_v_ff <= {PIPE{1'b0}};
            dq_o <= 16'h0000;
            dq_oe_o <= 1'b0;
            for (i = 0; i < PIPE; i = i + 1) begin
                pipe_d_ff[i] <= 16'h0000;
            end
        end else if (live) begin
            // Suspended clock freezes the line
            pipe_v_ff <= {pipe_v_ff[PIPE-2:0], rd_now};
            pipe_d_ff[0] <= mem_ff[mem_idx];
            for (i = 1; i < PIPE; i = i + 1) begin
                pipe_d_ff[i] <= pipe_d_ff[i-1];
            end
            // RULE8: output after the programmed latency for codes 2 to 7; codes 0 and 1 give two
            if (cl_eff == 3'h2) begin
                dq_o <= mem_ff[mem_idx];
                dq_oe_o <= rd_now;
            end else begin
                dq_o <= pipe_d_ff[cl_eff-3'h3];
                dq_oe_o <= pipe_v_ff[cl_eff-3'h3];
            end
        end
    end

    // ==========================================
    // Mode register and init tracking
    always @(posedge clk_i) begin
        if (rst_i) begin
            mode_ff <= `MODE_RST;
            mrs_gap_ff <= 2'h0;
            pre_seen_ff <= 1'b0;
            ref_cnt_ff <= 3'h0;
            mode_seen_ff <= 1'b0;
        end else begin
            if (is_mrs) begin
                // RULE4: all twelve bits become the op code
                mode_ff <= addr_i;
                mode_seen_ff <= 1'b1;
                mrs_gap_ff <= `MRS_GAP - 2'h1;
            end else if (mrs_gap_ff != 2'h0) begin
                mrs_gap_ff <= mrs_gap_ff - 2'h1;
            end
            // RULE2: precharge all first, then refreshes
            if (is_pre && ap && pwr_ok_ff) begin
                pre_seen_ff <= 1'b1;
            end
            // RULE3: refreshes counted whatever the mode load order
            if (is_ref && pre_seen_ff && ref_cnt_ff != 3'h7) begin
                ref_cnt_ff <= ref_cnt_ff + 3'h1;
            end
        end
    end

    // RULE1: power-up wait with gate and masks high
    always @(posedge clk_i) begin
        if (rst_i) begin
            pwr_cnt_ff <= 16'h0000;
            pwr_ok_ff <= 1'b0;
        end else if (!pwr_ok_ff) begin
            if (!(cke_i && &dqm_i)) begin
                pwr_cnt_ff <= 16'h0000;
            end else if (pwr_cnt_ff == PWR_CYC[15:0] - 16'h1) begin
                pwr_ok_ff <= 1'b1;
            end else begin
                pwr_cnt_ff <= pwr_cnt_ff + 16'h1;
            end
        end
    end

    // ==========================================
    // Wishbone slave, one wait state
    assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire wr_err = wb_req && wb_we_i && wb_adr_i == `REG_ERROR && wb_sel_i[0];
    wire init_done = pwr_ok_ff && pre_seen_ff && ref_cnt_ff >= 3'h2 && mode_seen_ff;
    assign status_lo = {st1, st0};

    // Error flags: set wins over write-one-to-clear
    always @(posedge clk_i) begin
        if (rst_i) begin
            err_ff <= 3'h0;
        end else begin
            // RULE1: commands during the power-up wait
            // RULE7: command too soon after mode load
            // RULE6: refused commands in a wrong bank state
            err_ff <= (err_ff & ~(wr_err ? wb_dat_i[2:0] : 3'h0)) |
                {bad, is_cmd && mrs_gap_ff != 2'h0, is_cmd && !pwr_ok_ff};
        end
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
            wprot_ff <= `CTRL_RST;
        end else begin
            wb_ack_o <= wb_req;
            if (wb_req && wb_we_i && wb_adr_i == `REG_CTRL && wb_sel_i[0]) begin
                wprot_ff <= wb_dat_i[`CTRL_WPROT];
            end
            case (wb_adr_i)
                `REG_MODE: wb_dat_o <= {20'h00000, mode_ff};
                `REG_STATUS: wb_dat_o <= {12'h000, init_done, mode_seen_ff, ref_cnt_ff,
                    pre_seen_ff, pwr_ok_ff, bact_ff, status_lo};
                `REG_ERROR: wb_dat_o <= {29'h0, err_ff};
                `REG_CTRL: wb_dat_o <= {31'h0, wprot_ff};
                default: wb_dat_o <= 32'h00000000;
            endcase
        end
    end

    // RULE13: power-down entry not modelled; host idles banks first
endmodule // sdram_cmd_core

// ---- design/sdram_cmd_map.vh ----
`ifndef SDRAM_CMD_MAP_VH
`define SDRAM_CMD_MAP_VH

// ==========================================
// Register offsets (byte addresses)
`define REG_MODE 8'h00
`define REG_STATUS 8'h04
`define REG_ERROR 8'h08
`define REG_CTRL 8'h0c

// ==========================================
// Mode register fields
`define MR_WM_MSB 11
`define MR_WM_LSB 9
`define MR_CL_MSB 6
`define MR_CL_LSB 4
`define MR_BT_BIT 3
`define MR_BL_MSB 2
`define MR_BL_LSB 0
`define MODE_RST 12'h020
`define WM_BURST 3'h0
`define WM_SINGLE 3'h1
`define BL_1 3'h0
`define BL_2 3'h1
`define BL_4 3'h2
`define BL_8 3'h3
`define BL_PAGE 3'h7

// ==========================================
// Command codes {ras_n, cas_n, we_n}
`define CMD_NOP 3'h7
`define CMD_BST 3'h6
`define CMD_READ 3'h5
`define CMD_WRITE 3'h4
`define CMD_ACT 3'h3
`define CMD_PRE 3'h2
`define CMD_REF 3'h1
`define CMD_MRS 3'h0

// ==========================================
// Address bits with a command meaning
`define BANK_BIT 11
`define AP_BIT 10

// ==========================================
// Timing
`define PWR_WAIT_US 100
`define CLK_MHZ 50
`define MRS_GAP 2'h2

// ==========================================
// Control and error bits
`define CTRL_WPROT 0
`define CTRL_RST 1'h0
`define ERR_EARLY 0
`define ERR_MRS_GAP 1
`define ERR_ILLEGAL 2

`endif

// ---- design/bank_state.v ----
`timescale 1ns/1ps
// ==========================================
// One bank's state, one-hot
module bank_state (
    input wire clk_i,
    input wire rst_i,
    input wire act_i,
    input wire rd_i,
    input wire wr_i,
    input wire ap_i,
    input wire pre_i,
    input wire stop_i,
    input wire done_i,
    output wire [5:0] state_o,
    output wire idle_o
);
    localparam [5:0] S_IDLE = 6'h01;
    localparam [5:0] S_ACT = 6'h02;
    localparam [5:0] S_RD = 6'h04;
    localparam [5:0] S_WR = 6'h08;
    localparam [5:0] S_RDAP = 6'h10;
    localparam [5:0] S_WRAP = 6'h20;

    reg [5:0] state_ff;
    reg [5:0] nxt_state;
    wire busy;

    assign busy = (state_ff != S_IDLE) && (state_ff != S_ACT);
    assign state_o = state_ff;
    assign idle_o = (state_ff == S_IDLE);

    // RULE17: per bank transitions
    always @* begin
        nxt_state = state_ff;
        if (pre_i) begin
            nxt_state = S_IDLE;
        end else if (act_i && state_ff == S_IDLE) begin
            nxt_state = S_ACT;
        end else if (rd_i) begin
            nxt_state = ap_i ? S_RDAP : S_RD;
        end else if (wr_i && done_i) begin
            nxt_state = ap_i ? S_IDLE : S_ACT;
        end else if (wr_i) begin
            nxt_state = ap_i ? S_WRAP : S_WR;
        end else if (busy && (stop_i || done_i)) begin
            // Auto-close banks drop to idle once the burst completes; a burst stop leaves them active
            case (state_ff)
                S_RDAP: nxt_state = stop_i ? S_ACT : S_IDLE;
                S_WRAP: nxt_state = stop_i ? S_ACT : S_IDLE;
                default: nxt_state = S_ACT;
            endcase
        end
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            state_ff <= S_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end
endmodule // bank_state

// ---- design/burst_col.v ----
`timescale 1ns/1ps
`include "sdram_cmd_map.vh"
// ==========================================
// Column of burst step idx
module burst_col #(
    parameter COL_W = 8
) (
    input wire [COL_W-1:0] start_i,
    input wire [COL_W-1:0] idx_i,
    input wire [2:0] bl_i,
    input wire bt_i,
    output reg [COL_W-1:0] col_o
);
    reg [COL_W-1:0] mask;
    reg [COL_W-1:0] sum;

    // RULE11: sequential or interleaved
    always @* begin
        sum = start_i + idx_i;
        case (bl_i)
            `BL_2: mask = {{(COL_W-1){1'b0}}, 1'b1};
            `BL_4: mask = {{(COL_W-2){1'b0}}, 2'h3};
            `BL_8: mask = {{(COL_W-3){1'b0}}, 3'h7};
            `BL_PAGE: mask = {COL_W{1'b1}};
            default: mask = {COL_W{1'b0}};
        endcase
        // Full page has no interleaved order, wraps sequentially
        if (bt_i && bl_i != `BL_PAGE) begin
            col_o = (start_i & ~mask) | ((start_i ^ idx_i) & mask);
        end else begin
            col_o = (start_i & ~mask) | (sum & mask);
        end
    end
endmodule // burst_col

// ---- sim/sdram_cmd_monitor.sv ----
`timescale 1ns/1ps
// ==========================================
// Port checker
module sdram_cmd_monitor (
    input wire clk_i,
    input wire rst_i,
    input wire [7:0] wb_adr_i,
    input wire wb_we_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire [31:0] wb_dat_o,
    input wire wb_ack_o,
    input wire cke_i,
    input wire cs_n_i,
    input wire ras_n_i,
    input wire cas_n_i,
    input wire we_n_i,
    input wire [11:0] addr_i,
    input wire [15:0] dq_o,
    input wire dq_oe_o
);
    reg [11:0] mode_ff;
    wire [2:0] code = {ras_n_i, cas_n_i, we_n_i};
    wire rd = cke_i && !cs_n_i && code == 3'h5;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Shadow of the mode word; refused loads never happen in this bench
    always @(posedge clk_i) begin
        if (rst_i) begin
            mode_ff <= 12'h020;
        end else if (cke_i && !cs_n_i && code == 3'h0) begin
            mode_ff <= addr_i;
        end
    end
    a_ack_one_cycle: assert property (
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack late");
    a_ack_single_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack too long");
    a_ack_needs_req: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    a_read_latency: assert property (
        $rose(dq_oe_o) && mode_ff[6:4] <= 3'h3
        |-> ((mode_ff[6:4] == 3'h3) ? $past(rd, 3) : $past(rd, 2)))
        else $error("read word at wrong latency");
    a_mode_readback: assert property (
        wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i) == 8'h00 |-> wb_dat_o[11:0] == mode_ff)
        else $error("mode word not captured");
    a_unmapped_zero: assert property (
        wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i) > 8'h0c |-> wb_dat_o == 32'h0)
        else $error("unmapped read not zero");
    a_burst_two_words: assert property (
        $rose(dq_oe_o) && mode_ff[2:0] == 3'h1 |=> dq_oe_o)
        else $error("burst of two cut short");
    a_reset_quiet: assert property (disable iff (1'b0)
        rst_i |=> !wb_ack_o && !dq_oe_o && dq_o == 16'h0)
        else $error("outputs busy in reset");
endmodule // sdram_cmd_monitor

bind sdram_cmd_core sdram_cmd_monitor u_sdram_cmd_monitor (.clk_i(clk_i), .rst_i(rst_i),
    .wb_adr_i(wb_adr_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .cke_i(cke_i), .cs_n_i(cs_n_i),
    .ras_n_i(ras_n_i), .cas_n_i(cas_n_i), .we_n_i(we_n_i), .addr_i(addr_i),
    .dq_o(dq_o), .dq_oe_o(dq_oe_o));

// ---- sim/host_model.sv ----
`timescale 1ns/1ps
// ==========================================
// Host controller model
module host_model (
    input wire clk_i,
    output logic cke_o,
    output logic cs_n_o,
    output logic ras_n_o,
    output logic cas_n_o,
    output logic we_n_o,
    output logic [11:0] addr_o,
    output logic [1:0] dqm_o,
    output logic [15:0] dq_o
);
    logic drv = 1'b0;
    initial begin
        cke_o = 1'b1;
        dqm_o = 2'h3;
        cs_n_o = 1'b1;
        {ras_n_o, cas_n_o, we_n_o} = 3'h7;
        addr_o = 12'h0;
        dq_o = 16'h5a5a;
    end
    // Released data line keeps moving, so no stale word passes
    always @(posedge clk_i) begin
        if (!drv) begin
            dq_o <= ~dq_o;
        end
    end
    task automatic cmd(input logic [2:0] c, input logic [11:0] a, input logic sel_n);
        @(posedge clk_i);
        cs_n_o <= sel_n;
        {ras_n_o, cas_n_o, we_n_o} <= c;
        addr_o <= a;
    endtask
    task automatic gate(input logic g);
        @(posedge clk_i);
        cke_o <= g;
    endtask
    task automatic no_op_cmd(input int n);
        repeat (n) cmd(3'h7, 12'h0, 1'b0);
    endtask
    task automatic mode_load(input logic [11:0] op);
        cmd(3'h2, 12'h400, 1'b0);
        no_op_cmd(1);
        cmd(3'h0, op, 1'b0);
        no_op_cmd(2);
    endtask
    task automatic init_seq(input int cyc, input logic [11:0] op);
        repeat (cyc) cmd(3'h7, 12'h0, 1'b1);
        dqm_o <= 2'h0;
        cmd(3'h2, 12'h400, 1'b0);
        repeat (2) begin
            no_op_cmd(1);
            cmd(3'h1, 12'h0, 1'b0);
        end
        no_op_cmd(1);
        mode_load(op);
    endtask
    task automatic wr_burst(input logic [11:0] a, input int n, input logic [15:0] w[8]);
        drv = 1'b1;
        for (int i = 0; i < n; i++) begin
            cmd((i == 0) ? 3'h4 : 3'h7, a, 1'b0);
            dq_o <= w[i];
        end
        no_op_cmd(1);
        drv = 1'b0;
    endtask
endmodule // host_model

// ---- sim/sdram_cmd_core_test.sv ----
`timescale 1ns/1ps
// ==========================================
// Self-checking bench
module sdram_cmd_core_test;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [7:0] wb_adr_i = 8'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic [3:0] wb_sel_i = 4'h0;
    logic wb_we_i = 1'b0;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o, cke, cs_n, ras_n, cas_n, we_n, dq_oe;
    logic [11:0] addr;
    logic [1:0] dqm;
    logic [15:0] dq_w, dq_r;
    logic [15:0] mem [512];
    int mismatches = 0;
    int n_checks = 0;
    logic [3:0] sel_q = 4'hf;
    always #10 clk_i = ~clk_i;
    sdram_cmd_core #(.COL_W(8), .PWR_CYC(20)) u_sdram_cmd_core (.clk_i(clk_i), .rst_i(rst_i),
        .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .cke_i(cke), .cs_n_i(cs_n), .ras_n_i(ras_n), .cas_n_i(cas_n), .we_n_i(we_n),
        .addr_i(addr), .dqm_i(dqm), .dq_i(dq_w), .dq_o(dq_r), .dq_oe_o(dq_oe));
    host_model u_host_model (.clk_i(clk_i), .cke_o(cke), .cs_n_o(cs_n), .ras_n_o(ras_n),
        .cas_n_o(cas_n), .we_n_o(we_n), .addr_o(addr), .dqm_o(dqm), .dq_o(dq_w));
    task automatic complete_run;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wb(input logic [7:0] a, input logic we, input logic [31:0] d,
        output logic [31:0] q);
        int k;
        @(posedge clk_i);
        wb_adr_i <= a;
        wb_we_i <= we;
        wb_dat_i <= d;
        wb_sel_i <= sel_q;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        for (k = 0; k < 50 && wb_ack_o !== 1'b1; k++) @(posedge clk_i);
        if (wb_ack_o !== 1'b1) begin
            check(32'h0, 32'h1);
            complete_run();
        end
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    // Error flags read, then cleared by writing ones
    task automatic err_is(input logic [31:0] exp);
        logic [31:0] q;
        wb(8'h08, 1'b0, 32'h0, q);
        check(q, exp);
        wb(8'h08, 1'b1, 32'h7, q);
    endtask
    function automatic int col_at(int s, int n, int i, int bt);
        return (s & ~(n - 1)) | (((bt != 0) ? (s ^ i) : (s + i)) & (n - 1));
    endfunction
    initial begin
        logic [31:0] q;
        logic [15:0] w[8];
        logic [11:0] op, a;
        int n, lat, bt, bank, s, bl;
        q = $urandom(32'h45fc8ad8);
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(8'h00, 1'b0, 32'h0, q);
        check(q, 32'h020);
        wb(8'h40, 1'b1, 32'hffffffff, q);
        wb(8'h40, 1'b0, 32'h0, q);
        check(q, 32'h0);
        // Write without the low byte select is dropped
        sel_q = 4'he;
        wb(8'h0c, 1'b1, 32'h1, q);
        sel_q = 4'hf;
        wb(8'h0c, 1'b0, 32'h0, q);
        check(q, 32'h0);
        u_host_model.init_seq(30, 12'h032);
        wb(8'h00, 1'b0, 32'h0, q);
        check(q, 32'h032);
        err_is(32'h0);
        u_host_model.cmd(3'h0, 12'h032, 1'b0);
        u_host_model.cmd(3'h1, 12'h0, 1'b0);
        u_host_model.no_op_cmd(2);
        err_is(32'h2);
        u_host_model.cmd(3'h5, 12'h0, 1'b0);
        u_host_model.no_op_cmd(4);
        err_is(32'h4);
        // Deselected activate must leave bank one idle
        u_host_model.cmd(3'h3, 12'h800, 1'b1);
        u_host_model.cmd(3'h4, 12'h800, 1'b0);
        u_host_model.no_op_cmd(2);
        err_is(32'h4);
        u_host_model.cmd(3'h3, 12'h0, 1'b0);
        u_host_model.cmd(3'h1, 12'h0, 1'b0);
        u_host_model.no_op_cmd(2);
        err_is(32'h4);
        // Last pass writes bank zero at the start column of pass seven in single write mode
        for (int k = 0; k < 9; k++) begin
            bl = (k == 8) ? 2 : k % 4;
            bt = (k == 8) ? 1 : k / 4;
            lat = 2 + k % 2;
            bank = k % 2;
            n = 1 << bl;
            if (k != 8) s = $urandom_range(255);
            op = 12'(((k == 8) ? 512 : 0) + lat * 16 + bt * 8 + bl);
            a = 12'(bank * 2048 + $urandom_range(3) * 256 + s);
            u_host_model.mode_load(op);
            u_host_model.cmd(3'h3, 12'(bank * 2048), 1'b0);
            for (int i = 0; i < 8; i++) w[i] = 16'($urandom);
            u_host_model.wr_burst(a, n, w);
            for (int i = 0; i < n; i++)
                if (k != 8 || i == 0) mem[bank * 256 + col_at(s, n, i, bt)] = w[i];
            u_host_model.cmd(3'h5, a | 12'h400, 1'b0);
            u_host_model.no_op_cmd(lat);
            for (int i = 0; i < n; i++) begin
                @(posedge clk_i);
                check({dq_oe, dq_r}, {1'b1, mem[bank * 256 + col_at(s, n, i, bt)]});
            end
        end
        // Page read, latency code 1 acts as 2, one paused edge repeats a word
        u_host_model.mode_load(12'h017);
        u_host_model.cmd(3'h3, 12'h000, 1'b0);
        s = s & 252;
        u_host_model.cmd(3'h5, 12'(s), 1'b0);
        u_host_model.no_op_cmd(1);
        u_host_model.gate(1'b0);
        u_host_model.gate(1'b1);
        for (int i = 0; i < 5; i++) begin
            if (i > 0) @(posedge clk_i);
            check({dq_oe, dq_r}, {1'b1, mem[s + ((i > 0) ? i - 1 : 0)]});
        end
        u_host_model.cmd(3'h6, 12'h000, 1'b0);
        u_host_model.no_op_cmd(1);
        @(posedge clk_i);
        check(dq_oe, 1'b0);
        wb(8'h04, 1'b0, 32'h0, q);
        check(q & 32'h1fff, 32'h0042);
        u_host_model.cmd(3'h3, 12'h800, 1'b0);
        u_host_model.cmd(3'h2, 12'h000, 1'b0);
        u_host_model.no_op_cmd(1);
        wb(8'h04, 1'b0, 32'h0, q);
        check(q & 32'h1fff, 32'h0081);
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(8'h00, 1'b0, 32'h0, q);
        check(q, 32'h020);
        complete_run();
    end
endmodule // sdram_cmd_core_test
